// ==== bbsr_host.sv ====
// host controller driving an async battery-backed byte sram
// Behaviour
// - host holds address for whole write, valid 75 ns before end
// - host holds address 5 ns after strobe rises
// - write data valid 35 ns before end, held after end
// - host keeps write strobe low at least 65 ns
// - host keeps output enable high during writes
`timescale 1ns/1ps
module bbsr_host #(
	parameter int RECOVERY_CYCLES = bbsr_pkg::RECOVERY_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic power_fail,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [bbsr_pkg::ADDR_W-1:0] req_addr,
	input wire logic [bbsr_pkg::DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [bbsr_pkg::DATA_W-1:0] rsp_rdata,
	output logic mem_ready,
	output bbsr_pkg::bbsr_pins_s pins,
	input wire logic [bbsr_pkg::DATA_W-1:0] data_bus_in,
	output logic [bbsr_pkg::DATA_W-1:0] data_bus_out,
	output logic data_bus_oe
);
	bbsr_pkg::bbsr_state_e st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt;
	bbsr_pkg::bbsr_pins_s pins_ff, nxt_pins;
	logic [bbsr_pkg::DATA_W-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic oe_ff, nxt_oe, rv_ff, nxt_rv;
	logic pf_s1_ff, pf_s2_ff, pf_prev_ff;
	logic [bbsr_pkg::DATA_W-1:0] din_s1_ff, din_s2_ff;
	logic rec_busy;

	// power fail flag is asynchronous to mclk, two flops first
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pf_s1_ff <= 1'b1;
			pf_s2_ff <= 1'b1;
			pf_prev_ff <= 1'b1;
			din_s1_ff <= '0;
			din_s2_ff <= '0;
		end
		else
		begin
			pf_s1_ff <= power_fail;
			pf_s2_ff <= pf_s1_ff;
			pf_prev_ff <= pf_s2_ff;
			din_s1_ff <= data_bus_in;
			din_s2_ff <= din_s1_ff;
		end
	end

	// recovery wait timer
	// restart the wait on each supply return; long, so a parameter
	bbsr_timer #(.W(24)) u_rec (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.load(pf_prev_ff && !pf_s2_ff),
		.load_val(24'(RECOVERY_CYCLES)),
		.busy(rec_busy)
	);

	// deselect gating
	// no new access while the flag or the recovery wait holds
	assign mem_ready = !pf_s2_ff && !rec_busy;
	assign req_ready = (st_ff == bbsr_pkg::ST_IDLE) && mem_ready;

	// access sequencer
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_pins = pins_ff;
		nxt_wd = wd_ff;
		nxt_rd = rd_ff;
		nxt_oe = oe_ff;
		nxt_rv = 1'b0;
		unique case (st_ff)
			bbsr_pkg::ST_IDLE:
			begin
				if (req_valid && req_ready)
				begin
					nxt_pins.byte_address = req_addr;
					nxt_pins.chip_sel_n = 1'b0;
					nxt_wd = req_wdata;
					if (req_write)
					begin
						nxt_pins.out_en_n = 1'b1;
						nxt_pins.wr_strobe_n = 1'b0;
						nxt_oe = 1'b1;
						nxt_cnt = 4'(bbsr_pkg::WR_CYC);
						nxt_st = bbsr_pkg::ST_WR;
					end
					else
					begin
						nxt_pins.out_en_n = 1'b0;
						// wait access delay plus two sync flops
						nxt_cnt = 4'(bbsr_pkg::RD_CYC + 2);
						nxt_st = bbsr_pkg::ST_RD;
					end
				end
			end
			bbsr_pkg::ST_RD:
			begin
				// sample only after the access delay
				if (cnt_ff == bbsr_pkg::CNT_ZERO)
				begin
					nxt_rd = din_s2_ff;
					nxt_rv = 1'b1;
					nxt_pins.chip_sel_n = 1'b1;
					nxt_pins.out_en_n = 1'b1;
					nxt_cnt = 4'(bbsr_pkg::TURN_CYC);
					nxt_st = bbsr_pkg::ST_TURN;
				end
				else
					nxt_cnt = cnt_ff - 4'h1;
			end
			bbsr_pkg::ST_WR:
			begin
				// strobe width and data setup covered by 75 ns
				// a started write runs to its end regardless
				if (cnt_ff == bbsr_pkg::CNT_ZERO)
				begin
					// both strobes rise together to end the write
					nxt_pins.wr_strobe_n = 1'b1;
					nxt_pins.chip_sel_n = 1'b1;
					nxt_cnt = 4'(bbsr_pkg::HOLD_CYC + 1);
					nxt_st = bbsr_pkg::ST_HOLD;
				end
				else
					nxt_cnt = cnt_ff - 4'h1;
			end
			bbsr_pkg::ST_HOLD:
			begin
				// address and data held past the end
				if (cnt_ff == bbsr_pkg::CNT_ZERO)
				begin
					nxt_oe = 1'b0;
					nxt_st = bbsr_pkg::ST_IDLE;
				end
				else
					nxt_cnt = cnt_ff - 4'h1;
			end
			bbsr_pkg::ST_TURN:
			begin
				// let memory release the bus before next access
				if (cnt_ff == bbsr_pkg::CNT_ZERO)
					nxt_st = bbsr_pkg::ST_IDLE;
				else
					nxt_cnt = cnt_ff - 4'h1;
			end
			default:
				nxt_st = bbsr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_ff <= bbsr_pkg::ST_IDLE;
			cnt_ff <= '0;
			pins_ff <= '{byte_address: '0, chip_sel_n: 1'b1,
				out_en_n: 1'b1, wr_strobe_n: 1'b1};
			wd_ff <= '0;
			rd_ff <= '0;
			oe_ff <= 1'b0;
			rv_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			pins_ff <= nxt_pins;
			wd_ff <= nxt_wd;
			rd_ff <= nxt_rd;
			oe_ff <= nxt_oe;
			rv_ff <= nxt_rv;
		end
	end

	assign pins = pins_ff;
	assign data_bus_out = wd_ff;
	assign data_bus_oe = oe_ff;
	assign rsp_valid = rv_ff;
	assign rsp_rdata = rd_ff;

	a_no_bus_fight: assert property (@(posedge mclk) disable iff (sys_rst)
		data_bus_oe |-> pins.out_en_n)
		else $error("host drives data bus while output enable low");
	a_strobe_width: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(pins.wr_strobe_n) |-> !pins.wr_strobe_n [*7])
		else $error("write strobe low too short");
	a_addr_stable: assert property (@(posedge mclk) disable iff (sys_rst)
		!pins.wr_strobe_n |=> $stable(pins.byte_address))
		else $error("address moved during write");
	a_data_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(pins.wr_strobe_n) |-> data_bus_oe && $stable(data_bus_out))
		else $error("write data not held at strobe rise");
	a_recov_block: assert property (@(posedge mclk) disable iff (sys_rst)
		(rec_busy || pf_s2_ff) |-> !req_ready)
		else $error("access accepted while protected");
	// select only falls after a take made while unprotected
	a_no_access_prot: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(pins.chip_sel_n) |-> $past(mem_ready))
		else $error("select fell while memory protected");
	a_read_wait: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(pins.out_en_n) |-> !rsp_valid [*8])
		else $error("read data taken before access delay");
	a_joint_fall: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(pins.wr_strobe_n) |-> $fell(pins.chip_sel_n))
		else $error("write strobe fell apart from select");
	a_addr_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(pins.wr_strobe_n) |=> $stable(pins.byte_address))
		else $error("address not held after write");
endmodule

// ==== bbsr_host_tb.sv ====
// self-checking bench for the sram host controller
`timescale 1ns/1ps
module bbsr_host_tb;
	localparam int REC = 20;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic power_fail = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready;
	logic req_write = 1'b0;
	logic [18:0] req_addr = 19'h00000;
	logic [7:0] req_wdata = 8'h00;
	logic rsp_valid;
	logic [7:0] rsp_rdata;
	logic mem_ready;
	bbsr_pkg::bbsr_pins_s pins;
	logic [7:0] dout;
	logic dut_oe;
	logic [7:0] m_q;
	logic m_oe;
	// released wire shows inverted data, not a lucky stale value
	wire [7:0] bus = dut_oe ? dout : (m_oe ? m_q : ~m_q);
	logic [7:0] ref_mem [logic [18:0]];
	int bad_count = 0;
	int total_checks = 0;
	integer seed = 32'h9f1b4f9b;
	int n;
	logic [31:0] r;
	time t_w;
	logic [18:0] a_w;
	bbsr_host #(.RECOVERY_CYCLES(REC)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
		.power_fail(power_fail), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ready(mem_ready),
		.pins(pins), .data_bus_in(bus), .data_bus_out(dout),
		.data_bus_oe(dut_oe));
	bbsr_sram_model mem_u (.pins(pins), .power_fail(power_fail), .bus(bus),
		.q(m_q), .q_oe(m_oe));
	// clock
	always #5 mclk = ~mclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [7:0] exp_rd(input logic [18:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : 8'h5a;
	endfunction
	// one request held until taken; reads wait for the answer
	task automatic access(input logic wr, input logic [18:0] a,
		input logic [7:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		#1;
		while (req_ready !== 1'b1 && k < 500)
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk(k < 500, 1);
		// a request port that never opens ends the run here
		if (k >= 500)
			give_verdict();
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		k = 0;
		if (wr)
			ref_mem[a] = d;
		else
		begin
			while (rsp_valid !== 1'b1 && k < 20)
			begin
				@(posedge mclk);
				#1;
				k++;
			end
			// access delay cycles, two sync flops, then the answer register
			chk(k, bbsr_pkg::RD_CYC + 3);
			chk(rsp_rdata, exp_rd(a));
			if (k >= 20)
				give_verdict();
		end
	endtask
	// wire watch on write strobes and bus ownership
	always @(negedge pins.wr_strobe_n)
	begin
		t_w = $time;
		a_w = pins.byte_address;
	end
	// the reset ramp of the strobe is no write end
	always @(posedge pins.wr_strobe_n)
		if (!sys_rst)
		begin
			chk($time - t_w >= 65, 1);
			chk(pins.byte_address, a_w);
			chk(dut_oe, 1);
		end
	always @(negedge mclk)
		if (dut_oe && m_oe)
			chk(0, 1);
	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		access(1'b1, 19'h00000, 8'ha5);
		access(1'b1, 19'h7ffff, 8'h3c);
		access(1'b0, 19'h00000, 8'h00);
		access(1'b0, 19'h7ffff, 8'h00);
		$display("test boundary done");
		repeat (40)
		begin
			r = $random(seed);
			access(r[8], {15'h0000, r[3:0]}, r[31:24]);
		end
		$display("test random done");
		access(1'b1, 19'h00010, 8'h77);
		power_fail = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk(mem_ready, 0);
		chk(req_ready, 0);
		repeat (150) @(posedge mclk);
		#1;
		power_fail = 1'b0;
		n = 0;
		while (mem_ready !== 1'b1 && n < 200)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(n >= REC && n < 200, 1);
		if (n >= 200)
			give_verdict();
		access(1'b0, 19'h00010, 8'h00);
		$display("test power fail done");
		give_verdict();
	end
endmodule

// ==== bbsr_pkg.sv ====
// shared constants and carrier types for the sram host controller
package bbsr_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;
	// read: address access delay and output enable access, ns
	localparam int ADDRESS_ACCESS_DELAY_NS = 85;
	localparam int OE_ACCESS_NS = 45;
	// write timing, ns
	localparam int ADDR_TO_END_NS = 75;
	localparam int STROBE_WIDTH_NS = 65;
	localparam int DATA_SETUP_NS = 35;
	localparam int ADDR_HOLD_NS = 5;
	localparam int STROBE_TO_TRISTATE_DELAY_NS = 30;
	localparam int OUTPUT_HOLD_DELAY_NS = 5;
	// least times round up to whole cycles
	localparam int RD_CYC = (ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WR_CYC = (ADDR_TO_END_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int TURN_CYC = (STROBE_TO_TRISTATE_DELAY_NS + CLK_PERIOD_NS
		- 1) / CLK_PERIOD_NS;
	// recovery interval, longest figure, in microseconds
	localparam int RECOVERY_INTERVAL_US = 140000;
	localparam int RECOVERY_CYC = RECOVERY_INTERVAL_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD = 3'b001,
		ST_WR = 3'b010,
		ST_HOLD = 3'b011,
		ST_TURN = 3'b100
	} bbsr_state_e;

	// pins toward the memory
	typedef struct packed {
		logic [ADDR_W-1:0] byte_address;
		logic chip_sel_n;
		logic out_en_n;
		logic wr_strobe_n;
	} bbsr_pins_s;
endpackage

// ==== bbsr_sram_model.sv ====
// behavioural battery-backed byte sram facing the host
`timescale 1ns/1ps
module bbsr_sram_model #(
	parameter int ACC_NS = 85,
	parameter int WP_NS = 1000,
	parameter int REC_NS = 150
) (
	input wire bbsr_pkg::bbsr_pins_s pins,
	input wire logic power_fail,
	input wire logic [7:0] bus,
	output logic [7:0] q,
	output logic q_oe
);
	logic [7:0] mem [logic [18:0]];
	logic prot = 1'b0;
	// set only once select and strobe are both low, so the reset ramp of
	// the strobes from unknown to high does not store a stray byte
	logic wr_on = 1'b0;
	time t_a = 0;
	time t_g = 0;
	always @(pins.byte_address or pins.chip_sel_n)
		t_a = $time;
	always @(negedge pins.out_en_n)
		t_g = $time;
	always @(power_fail)
		if (power_fail)
			prot <= #WP_NS 1'b1;
		else
			prot <= #REC_NS 1'b0;
	always @(pins.chip_sel_n or pins.wr_strobe_n)
		if (!pins.chip_sel_n && !pins.wr_strobe_n)
			wr_on = 1'b1;
	always @(posedge (pins.chip_sel_n | pins.wr_strobe_n))
	begin
		if (!prot && wr_on)
			mem[pins.byte_address] = bus;
		wr_on = 1'b0;
	end
	assign q_oe = !pins.chip_sel_n && !pins.out_en_n && pins.wr_strobe_n
		&& !power_fail;
	initial
		q = 8'h00;
	// toggling junk until access done, never a stale hit
	always #1
		if ($time >= t_a + ACC_NS && $time >= t_g + 45)
			q = mem.exists(pins.byte_address) ? mem[pins.byte_address] : 8'h5a;
		else
			q = ~q;
endmodule

// ==== bbsr_timer.sv ====
// down counter used for the recovery interval
`timescale 1ns/1ps
module bbsr_timer #(
	parameter int W = 24
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic busy
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	// load wins over counting down
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (load)
			nxt_cnt = load_val;
		else if (cnt_ff != '0)
			nxt_cnt = cnt_ff - W'(1);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign busy = (cnt_ff != '0) || load;
endmodule
